/* inc/eam_pkg.sv */
/*
  Shared constants and types of the extended alert mask block.
  Assumes one 200 MHz clock domain and a byte-level command port
  driven by the device's own bus engine in that same domain.
*/
package eam_pkg;

  localparam int MASK_W = 56;
  localparam int BLK_BYTES = 7;
  localparam logic [7:0] CMD_CODE = 8'hCF;
  localparam logic [7:0] BLK_COUNT = 8'h07;
  localparam logic [3:0] LAST_DATA_IDX = 4'h7;
  localparam logic [3:0] IDX_MAX = 4'hF;
  localparam int NVM_DEFAULT_POS = 6;
  localparam logic [7:0] RD_PAST_END = 8'h00;
  localparam logic [MASK_W-1:0] MASK_ZERO = 56'h0;

  // Mask bit positions, same as the extended fault-status layout
  localparam int ILLEGAL_WRITE_POS = 55;
  localparam int MALFORMED_GROUP_CMD_POS = 54;
  localparam int GROUP_READ_POS = 53;
  localparam int MISC_COMM_ERROR_POS = 52;
  localparam int HOST_ABORT_POS = 51;
  localparam int ARBITRATION_LOSS_POS = 50;
  localparam int COUNT_BYTE_NAK_POS = 49;
  localparam int TOO_FEW_BYTES_POS = 45;
  localparam int TOO_MANY_BYTES_POS = 44;
  localparam int UNDERSIZE_BLOCK_POS = 43;
  localparam int OVERSIZE_BLOCK_POS = 42;
  localparam int PROTECTED_WRITE_POS = 41;
  localparam int POS_SENSE_OPEN_B_POS = 39;
  localparam int POS_SENSE_OPEN_A_POS = 38;
  localparam int NEG_SENSE_OPEN_B_POS = 37;
  localparam int NEG_SENSE_OPEN_A_POS = 36;
  localparam int SYNC_FAULT_POS = 28;
  localparam int UPDATE_DENIED_POS = 26;
  localparam int INVALID_STARTUP_POS = 25;
  localparam int BAD_ADDR_PIN_POS = 24;
  localparam int PHASE_SETUP_ERROR_POS = 19;
  localparam int CONFIG_FILE_ERROR_POS = 18;
  localparam int TEMP_ALERT_LOW_B_POS = 15;
  localparam int TEMP_ALERT_LOW_A_POS = 14;
  localparam int PREBIAS_OVERVOLT_B_POS = 5;
  localparam int PREBIAS_OVERVOLT_A_POS = 4;
  localparam int TRACKING_OVERVOLT_B_POS = 3;
  localparam int TRACKING_OVERVOLT_A_POS = 2;
  localparam int FIXED_OVERVOLT_B_POS = 1;
  localparam int FIXED_OVERVOLT_A_POS = 0;

  localparam logic [MASK_W-1:0] BIT1 = 56'h1;

  // Implemented mask bits; every other position is reserved
  localparam logic [MASK_W-1:0] WR_MASK =
    (BIT1 << ILLEGAL_WRITE_POS) | (BIT1 << MALFORMED_GROUP_CMD_POS) |
    (BIT1 << GROUP_READ_POS) | (BIT1 << MISC_COMM_ERROR_POS) |
    (BIT1 << HOST_ABORT_POS) | (BIT1 << ARBITRATION_LOSS_POS) |
    (BIT1 << COUNT_BYTE_NAK_POS) | (BIT1 << TOO_FEW_BYTES_POS) |
    (BIT1 << TOO_MANY_BYTES_POS) | (BIT1 << UNDERSIZE_BLOCK_POS) |
    (BIT1 << OVERSIZE_BLOCK_POS) | (BIT1 << PROTECTED_WRITE_POS) |
    (BIT1 << POS_SENSE_OPEN_B_POS) | (BIT1 << POS_SENSE_OPEN_A_POS) |
    (BIT1 << NEG_SENSE_OPEN_B_POS) | (BIT1 << NEG_SENSE_OPEN_A_POS) |
    (BIT1 << SYNC_FAULT_POS) | (BIT1 << UPDATE_DENIED_POS) |
    (BIT1 << INVALID_STARTUP_POS) | (BIT1 << BAD_ADDR_PIN_POS) |
    (BIT1 << PHASE_SETUP_ERROR_POS) | (BIT1 << CONFIG_FILE_ERROR_POS) |
    (BIT1 << TEMP_ALERT_LOW_B_POS) | (BIT1 << TEMP_ALERT_LOW_A_POS) |
    (BIT1 << PREBIAS_OVERVOLT_B_POS) | (BIT1 << PREBIAS_OVERVOLT_A_POS) |
    (BIT1 << TRACKING_OVERVOLT_B_POS) |
    (BIT1 << TRACKING_OVERVOLT_A_POS) |
    (BIT1 << FIXED_OVERVOLT_B_POS) | (BIT1 << FIXED_OVERVOLT_A_POS);

  // Transaction states, Gray coded along idle -> selected -> discard
  typedef enum logic [1:0] {
    EAM_IDLE = 2'b00,
    EAM_SEL = 2'b01,
    EAM_DISCARD = 2'b11
  } eam_state_t;

  // One cycle strobes from the device bus engine
  typedef struct packed {
    logic start;
    logic stop;
    logic wr_byte;
    logic rd_byte;
    logic [7:0] cmd;
    logic [7:0] data;
  } eam_txn_t;

  // Block length faults seen on a write to this command
  typedef struct packed {
    logic too_few;
    logic too_many;
    logic size_small;
    logic size_big;
  } eam_err_t;

endpackage

/* src/eam_top.sv */
/*
  Extended alert mask register with its alert gating.
  Assumes the bus engine, the fault-status flags and the nonvolatile
  default bit all live in the clock_in domain.
*/
`timescale 1ns/1ps

// What this block does
// - Clear mask bit lets its condition assert alert; set bit blocks it.
// - Mask bit positions match the extended fault-status positions.
// - At reset all implemented mask bits load from vendor mask byte bit 6; reserved bits load 0.
// - Mask bits change at run time immediately; no per-bit backup.
// - Seven-byte block write and block read; no paging.
// - Bit 55 masks write to read-only command.
// - Bit 54 masks bad group command; bit 53 group with read.
// - Bit 52 masks any other communication error.
// - Bit 51 masks host abort; bit 50 masks arbitration loss.
// - Bit 49 masks host not-acknowledge of block size byte.
// - Bit 45 masks too few bytes; bit 44 too many bytes.
// - Bit 43 masks block too small; bit 42 block too large.
// - Bit 41 masks write to write-protected register.
// - Bits 39 and 38 mask positive sense open, channels B and A.
// - Bits 37 and 36 mask negative sense open, channels B and A.
// - Bit 28 masks synchronisation fault.
// - Bit 26 masks update not allowed; bit 24 bad address pin.
// - Bit 19 masks bad phase setup; bit 18 bad config file.
// - Bits 15 and 14 mask temperature alert low, channels B and A.
// - Bits 5..0 mask prebias, tracking, fixed overvoltage, B high.
module eam_top (
  // Clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // Nonvolatile defaults and fault flags
  input wire logic [7:0] vendor_alert_mask_byte_in,
  input wire logic [eam_pkg::MASK_W-1:0] extra_fault_flags_in,
  // Command port from the bus engine
  input wire eam_pkg::eam_txn_t txn_in,
  output eam_pkg::eam_txn_t unused_out_placeholder_n,
  // Read answer
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  // Mask state, block faults and alert request
  output logic [eam_pkg::MASK_W-1:0] mask_out,
  output eam_pkg::eam_err_t blk_err_out,
  output logic alert_req_out
);

  logic rst_meta_ff;
  logic rst_n_ff;

  eam_pkg::eam_state_t state_ff;
  eam_pkg::eam_state_t nxt_state;
  logic [3:0] idx_ff;
  logic [3:0] nxt_idx;
  logic is_write_ff;
  logic nxt_is_write;
  logic load_pend_ff;
  logic nxt_load_pend;
  logic [eam_pkg::MASK_W-1:0] mask_ff;
  logic [eam_pkg::MASK_W-1:0] nxt_mask;
  logic [eam_pkg::MASK_W-1:0] stage_ff;
  logic [eam_pkg::MASK_W-1:0] nxt_stage;
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;
  logic rd_valid_ff;
  logic nxt_rd_valid;
  eam_pkg::eam_err_t err_ff;
  eam_pkg::eam_err_t nxt_err;
  logic alert_ff;
  logic nxt_alert;
  logic [2:0] byte_sel;

  // Reset release through two flops
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // Data byte 1 maps to mask bits 7:0, byte 7 to bits 55:48
  assign byte_sel = 3'(idx_ff - 4'h1);

  always_comb begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_is_write = is_write_ff;
    nxt_load_pend = 1'b0;
    nxt_mask = mask_ff;
    nxt_stage = stage_ff;
    nxt_rd_data = rd_data_ff;
    nxt_rd_valid = 1'b0;
    nxt_err = '0;

    if (load_pend_ff) begin
      // Implemented mask bits follow the one nonvolatile default bit
      nxt_mask = {eam_pkg::MASK_W{
        vendor_alert_mask_byte_in[eam_pkg::NVM_DEFAULT_POS]}}
        & eam_pkg::WR_MASK;
    end

    if (txn_in.start) begin
      // Single page: only the command code selects the register
      if (txn_in.cmd == eam_pkg::CMD_CODE) begin
        nxt_state = eam_pkg::EAM_SEL;
      end else begin
        nxt_state = eam_pkg::EAM_IDLE;
      end
      nxt_idx = 4'h0;
      nxt_is_write = 1'b0;
      nxt_stage = eam_pkg::MASK_ZERO;
    end else begin
      case (state_ff)
        eam_pkg::EAM_IDLE: begin
          nxt_state = eam_pkg::EAM_IDLE;
        end
        eam_pkg::EAM_SEL: begin
          if (txn_in.wr_byte) begin
            nxt_is_write = 1'b1;
            if (idx_ff != eam_pkg::IDX_MAX) begin
              nxt_idx = idx_ff + 4'h1;
            end
            if (idx_ff == 4'h0) begin
              // Byte count must be exactly seven
              if (txn_in.data < eam_pkg::BLK_COUNT) begin
                nxt_err.size_small = 1'b1;
                nxt_state = eam_pkg::EAM_DISCARD;
              end else if (txn_in.data > eam_pkg::BLK_COUNT) begin
                nxt_err.size_big = 1'b1;
                nxt_state = eam_pkg::EAM_DISCARD;
              end
            end else if (idx_ff <= eam_pkg::LAST_DATA_IDX) begin
              nxt_stage[8*byte_sel +: 8] = txn_in.data;
            end else begin
              nxt_err.too_many = 1'b1;
              nxt_state = eam_pkg::EAM_DISCARD;
            end
          end else if (txn_in.rd_byte) begin
            nxt_rd_valid = 1'b1;
            if (idx_ff != eam_pkg::IDX_MAX) begin
              nxt_idx = idx_ff + 4'h1;
            end
            if (idx_ff == 4'h0) begin
              nxt_rd_data = eam_pkg::BLK_COUNT;
            end else if (idx_ff <= eam_pkg::LAST_DATA_IDX) begin
              nxt_rd_data = mask_ff[8*byte_sel +: 8];
            end else begin
              nxt_rd_data = eam_pkg::RD_PAST_END;
            end
          end else if (txn_in.stop) begin
            nxt_state = eam_pkg::EAM_IDLE;
            if (is_write_ff) begin
              if (idx_ff == 4'h8) begin
                // Commit takes effect at once; no per-bit backup
                nxt_mask = nxt_stage & eam_pkg::WR_MASK;
              end else begin
                nxt_err.too_few = 1'b1;
              end
            end
          end
        end
        eam_pkg::EAM_DISCARD: begin
          // Rest of a faulty write is dropped until stop
          if (txn_in.stop) begin
            nxt_state = eam_pkg::EAM_IDLE;
          end
        end
        default: begin
          nxt_state = eam_pkg::EAM_IDLE;
        end
      endcase
    end

    // Set mask bit blocks the matching flag; reserved bits never alert
    nxt_alert = |(extra_fault_flags_in & ~mask_ff
      & eam_pkg::WR_MASK);
  end

  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= eam_pkg::EAM_IDLE;
      idx_ff <= 4'h0;
      is_write_ff <= 1'b0;
      load_pend_ff <= 1'b1;
      mask_ff <= eam_pkg::MASK_ZERO;
      stage_ff <= eam_pkg::MASK_ZERO;
      rd_data_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
      err_ff <= '0;
      alert_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      is_write_ff <= nxt_is_write;
      load_pend_ff <= nxt_load_pend;
      mask_ff <= nxt_mask;
      stage_ff <= nxt_stage;
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
      err_ff <= nxt_err;
      alert_ff <= nxt_alert;
    end
  end

  // Bit meanings carried by mask_ff, same positions as the flags:
  // 55..49 bus access faults, 45..41 block length and lock faults
  // 39..36 sense opens, 28 sync, 26..24 and 19..18 setup faults
  // 15..14 temperature alert low, 5..0 overvoltage faults
  assign mask_out = mask_ff;
  assign rd_data_out = rd_data_ff;
  assign rd_valid_out = rd_valid_ff;
  assign blk_err_out = err_ff;
  assign alert_req_out = alert_ff;
  assign unused_out_placeholder_n = '0;

endmodule

/* testbench/eam_host_model.sv */
/*
  Bus engine model issuing block writes and reads to the mask.
  Assumes strobes are sampled on the rising edge of clock_in.
*/
`timescale 1ns/1ps
module eam_host_model (
  // Clock
  input wire logic clock_in,
  // Strobes and answers
  output eam_pkg::eam_txn_t txn_out,
  input wire logic [7:0] rd_data_in,
  input wire logic rd_valid_in
);
  logic [7:0] rx_q [$];
  initial txn_out = '0;
  always @(posedge clock_in) if (rd_valid_in) rx_q.push_back(rd_data_in);
  task automatic put(input logic [3:0] k, input logic [7:0] c, d);
    @(posedge clock_in);
    #1;
    txn_out = eam_pkg::eam_txn_t'({k, c, d});
  endtask
  // Released fields show inverted data, never the last value
  task automatic idle();
    put(4'h0, ~txn_out.cmd, ~txn_out.data);
  endtask
  task automatic wr_blk(input logic [7:0] c, n, input int b,
                        input logic [63:0] v);
    put(4'h8, c, 8'h00);
    put(4'h2, 8'h00, n);
    for (int k = 0; k < b; k++) put(4'h2, 8'h00, v[8*k+:8]);
    put(4'h4, 8'h00, 8'h00);
    idle();
  endtask
  task automatic rd_blk(input int b);
    rx_q.delete();
    put(4'h8, eam_pkg::CMD_CODE, 8'h00);
    repeat (b) put(4'h1, 8'h00, 8'h00);
    put(4'h4, 8'h00, 8'h00);
    idle();
    @(posedge clock_in);
  endtask
endmodule

/* testbench/eam_top_bench.sv */
/*
  Self-checking bench of the extended alert mask block.
  Assumes the host model drives the command port in place of the engine.
*/
`timescale 1ns/1ps
module eam_top_bench;
  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] vendor = 8'h00;
  logic [55:0] flags = 56'h0;
  logic [55:0] v = 56'hF0E1D2C3B4A596;
  eam_pkg::eam_txn_t txn;
  eam_pkg::eam_txn_t spare;
  eam_pkg::eam_err_t blk_err;
  logic [7:0] rd_data;
  logic rd_valid;
  logic [55:0] mask;
  logic alert;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  always #2.5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      print_verdict();
    end
  end
  eam_top uut (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .vendor_alert_mask_byte_in(vendor), .extra_fault_flags_in(flags),
    .txn_in(txn), .unused_out_placeholder_n(spare), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .mask_out(mask), .blk_err_out(blk_err),
    .alert_req_out(alert));
  eam_host_model host (.clock_in(clock_in), .txn_out(txn),
    .rd_data_in(rd_data), .rd_valid_in(rd_valid));
  task automatic chk(input string n, input logic [63:0] e, g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic do_reset(input logic [7:0] b);
    #1;
    vendor = b;
    arst_n_in = 1'b0;
    repeat (5) @(posedge clock_in);
    #1;
    arst_n_in = 1'b1;
    repeat (8) @(posedge clock_in);
    #1;
  endtask
  task automatic t_por();
    do_reset(8'h40);
    chk("por mask", eam_pkg::WR_MASK, mask);
    do_reset(8'hBF);
    chk("por mask", 0, mask);
    chk("spare port", 0, spare);
    $display("test por done");
  endtask
  task automatic t_block();
    logic [7:0] e;
    host.wr_blk(eam_pkg::CMD_CODE, 8'h07, 7, v);
    chk("mask", v & eam_pkg::WR_MASK, mask);
    host.rd_blk(9);
    chk("read len", 9, host.rx_q.size());
    for (int k = 0; k < 9; k++) begin
      e = (k == 0) ? 8'h07 : (k == 8) ? 8'h00 :
        8'((v & eam_pkg::WR_MASK) >> (8 * (k - 1)));
      chk("read byte", e, host.rx_q[k]);
    end
    $display("test block done");
  endtask
  task automatic t_refuse();
    logic [7:0] c [5] = '{8'hCF, 8'hCF, 8'hCF, 8'hCF, 8'hCE};
    logic [7:0] n [5] = '{8'h06, 8'h08, 8'h07, 8'h07, 8'h07};
    int b [5] = '{7, 7, 6, 8, 7};
    logic [3:0] e [5] = '{4'h2, 4'h1, 4'h8, 4'h4, 4'h0};
    logic [3:0] seen;
    for (int i = 0; i < 5; i++) begin
      seen = 4'h0;
      // Collect every error pulse while the write runs
      fork
        host.wr_blk(c[i], n[i], b[i], {8'h5A, ~v});
        repeat (b[i] + 4) begin
          @(posedge clock_in);
          #1;
          seen = seen | 4'(blk_err);
        end
      join
      chk("block error", e[i], seen);
      chk("mask kept", v & eam_pkg::WR_MASK, mask);
    end
    $display("test refuse done");
  endtask
  task automatic t_gate();
    logic [55:0] b;
    for (int i = 0; i < 56; i++) begin
      b = eam_pkg::BIT1 << i;
      host.wr_blk(eam_pkg::CMD_CODE, 8'h07, 7, eam_pkg::WR_MASK & ~b);
      flags = b;
      repeat (2) @(posedge clock_in);
      #1;
      chk("alert", eam_pkg::WR_MASK[i], alert);
      flags = ~b;
      repeat (2) @(posedge clock_in);
      #1;
      chk("alert", 0, alert);
      // Per-bit masking of every named condition
      // Per-bit masking continued
    end
    $display("test gate done");
  endtask
  initial begin
    t_por();
    t_block();
    t_refuse();
    t_gate();
    print_verdict();
  end
endmodule

/* testbench/eam_top_sva.sv */
/*
  Port checker for the extended alert mask block.
  Assumes it is bound to eam_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module eam_top_sva (
  // Clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // Inputs
  input wire logic [7:0] vendor_alert_mask_byte_in,
  input wire logic [eam_pkg::MASK_W-1:0] extra_fault_flags_in,
  input wire eam_pkg::eam_txn_t txn_in,
  // Outputs
  input wire logic [7:0] rd_data_out,
  input wire logic rd_valid_out,
  input wire logic [eam_pkg::MASK_W-1:0] mask_out,
  input wire eam_pkg::eam_err_t blk_err_out,
  input wire logic alert_req_out
);
  logic [2:0] up_ff;
  logic [2:0] nxt_up;
  logic ready;
  // Edges since reset release, so past values predate nothing stale
  always_comb nxt_up = (up_ff == 3'h7) ? up_ff : up_ff + 3'h1;
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) up_ff <= 3'h0;
    else up_ff <= nxt_up;
  end
  assign ready = (up_ff == 3'h7);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_sel;
    txn_in.start && txn_in.cmd == eam_pkg::CMD_CODE;
  endsequence
  sequence s_sel_rd; s_sel ##1 txn_in.rd_byte; endsequence
  sequence s_sel_wr; s_sel ##1 txn_in.wr_byte; endsequence
  property p_alert_gate;
    ready |-> alert_req_out == |($past(extra_fault_flags_in)
      & ~$past(mask_out) & eam_pkg::WR_MASK);
  endproperty
  property p_reserved_zero;
    (mask_out & ~eam_pkg::WR_MASK) == eam_pkg::MASK_ZERO;
  endproperty
  property p_rd_cause; rd_valid_out |-> $past(txn_in.rd_byte); endproperty
  property p_mask_hold;
    ready && !$stable(mask_out) |-> $past(txn_in.stop);
  endproperty
  property p_por_load;
    up_ff == 3'h5 |-> mask_out == ({eam_pkg::MASK_W{
      vendor_alert_mask_byte_in[eam_pkg::NVM_DEFAULT_POS]}}
      & eam_pkg::WR_MASK);
  endproperty
  property p_count_byte;
    s_sel_rd |=> rd_valid_out && rd_data_out == eam_pkg::BLK_COUNT;
  endproperty
  property p_size_small;
    s_sel_wr ##0 txn_in.data < eam_pkg::BLK_COUNT |=> blk_err_out.size_small;
  endproperty
  property p_size_big;
    s_sel_wr ##0 txn_in.data > eam_pkg::BLK_COUNT |=> blk_err_out.size_big;
  endproperty
  a_alert_gate: assert property (p_alert_gate)
    else $error("alert request mismatch");
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved mask bit set");
  a_rd_cause: assert property (p_rd_cause)
    else $error("read answer without read");
  a_mask_hold: assert property (p_mask_hold)
    else $error("mask changed without stop");
  a_por_load: assert property (p_por_load)
    else $error("reset mask load wrong");
  a_count_byte: assert property (p_count_byte)
    else $error("first read byte not count");
  a_size_small: assert property (p_size_small)
    else $error("small count not flagged");
  a_size_big: assert property (p_size_big)
    else $error("big count not flagged");
endmodule
bind eam_top eam_top_sva u_sva (.clock_in(clock_in), .arst_n_in(arst_n_in),
  .vendor_alert_mask_byte_in(vendor_alert_mask_byte_in),
  .extra_fault_flags_in(extra_fault_flags_in), .txn_in(txn_in),
  .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
  .mask_out(mask_out), .blk_err_out(blk_err_out),
  .alert_req_out(alert_req_out));
